/* aspu_serial_port.v */
// Asynchronous serial port with 8-bit and 9-bit frames and control register
// Function
// - 8-bit frame: start, 8 data LSB-first, stop
// - Control bit 7 selects 8 or 9 bit
// - 8-bit accept: buffer data, stop to ninth bit
// - Writing data buffer starts transmission
// - Transmit-done set at stop-bit start
// - Receive only while receive enable set
// - 8-bit accept: done clear, stop checked if enabled
// - Overrun keeps first byte, drops later frames
// - Accept loads buffer, ninth bit, done flag
// - 9-bit frame adds ninth transmit bit
// - 9-bit: ninth bit stored, stop ignored
// - 9-bit accept: ninth bit checked if enabled
// - Either flag raises one gated interrupt
// - Receive-done set when stop bit sampled
// - Only software clears the done flags
// - Control bit 6 reads one always
// - Bit clocks are half timer overflow rate
// - Receive timer reloads on start detection
// - Data writes go transmit, reads receive
`timescale 1ns/1ps
`default_nettype none
`include "aspu_regs.vh"
module aspu_serial_port (
    input  wire       i_clock,         // 40 MHz system clock
    input  wire       i_rst_n,         // Asynchronous reset, active low
    input  wire       i_timer_tick,    // Bit timer count enable pulse
    input  wire [7:0] i_timer_reload,  // Bit timer reload value
    input  wire       i_int_enable,    // Port interrupt enable
    input  wire [7:0] i_addr,          // Register address
    input  wire       i_wr,            // Register write strobe
    input  wire       i_rd,            // Register read strobe
    input  wire [7:0] i_wdata,         // Register write data
    output reg  [7:0] o_rdata,         // Register read data
    input  wire       i_serial_in_pin, // Receive line
    output reg        o_serial_out_pin,// Transmit line
    output wire       o_irq            // Port interrupt request
);
    // ============================================================
    // Declarations
    // Frame states; the transmitter uses all four, the receiver all but ST_STOP
    localparam ST_IDLE  = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA  = 2'h2;
    localparam ST_STOP  = 2'h3;

    // Register file, shift paths and one-cycle event strobes
    reg  [7:0] ctrl_q;
    reg  [7:0] rx_buf_q;
    reg  [1:0] tx_st_q;
    reg  [8:0] tx_shift_q;
    reg  [3:0] tx_cnt_q;
    reg  [1:0] rx_st_q;
    reg  [8:0] rx_shift_q;
    reg  [3:0] rx_cnt_q;
    reg  [4:0] rx_sub_q;
    reg        rx_prev_q;
    reg        tx_done_set;
    reg        rx_done_set;
    reg        rx_load;
    // Timer pulses, decodes and receive checks
    wire       tx_bit;
    wire       rx_os;
    wire       rx_fall;
    wire       nine;
    wire       wr_ctrl;
    wire       wr_data;
    wire       rx_ok;
    wire       rx_ninth;
    reg  [4:0] tx_sub_q;

    // Address decode shared by read and write paths
    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // Bit count from start to stop; shared by transmitter and receiver
    function [3:0] frame_bits;
        input fmt;
        begin
            frame_bits = fmt ? `ASPU_BITS_9BIT : `ASPU_BITS_8BIT;
        end
    endfunction

    assign nine    = ctrl_q[`ASPU_BIT_FMT];
    assign wr_ctrl = i_wr & hit(i_addr, `ASPU_CTRL_ADDR);
    assign wr_data = i_wr & hit(i_addr, `ASPU_DATA_ADDR);

    // ============================================================
    // Bit timers
    // Transmit timer free-runs; one bit is sixteen half-rate ticks
    // After reset it counts up from zero, so no bit clock exists until it
    // first wraps; the start bit may also be short of a full bit by up to one half-rate tick period less one cycle
    aspu_bit_timer #(
        .WIDTH (8)
    ) u_tx_timer (
        .i_clock    (i_clock),
        .i_rst_n    (i_rst_n),
        .i_tick     (i_timer_tick),
        .i_reload   (i_timer_reload),
        .i_restart  (1'b0),
        .o_overflow (),
        .o_half     (tx_bit)
    );

    // Receive copy is forced to reload on a start edge
    // so its phase follows the remote sender, not the transmit timer
    aspu_bit_timer #(
        .WIDTH (8)
    ) u_rx_timer (
        .i_clock    (i_clock),
        .i_rst_n    (i_rst_n),
        .i_tick     (i_timer_tick),
        .i_reload   (i_timer_reload),
        .i_restart  (rx_fall),
        .o_overflow (),
        .o_half     (rx_os)
    );

    // ============================================================
    // Transmitter
    // A tick divider gives one bit per sixteen half-rate pulses
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_st_q          <= ST_IDLE;
            tx_shift_q       <= 9'h1FF;
            tx_cnt_q         <= 4'h0;
            tx_sub_q         <= 5'h00;
            o_serial_out_pin <= 1'b1;
            tx_done_set      <= 1'b0;
        end else begin
            tx_done_set <= 1'b0;
            case (tx_st_q)
                ST_IDLE: begin
                    o_serial_out_pin <= 1'b1;
                    if (wr_data) begin
                        tx_shift_q <= {ctrl_q[`ASPU_BIT_TB8], i_wdata};
                        tx_cnt_q   <= frame_bits(nine);
                        tx_sub_q   <= 5'h00;
                        tx_st_q    <= ST_START;
                        o_serial_out_pin <= 1'b0;
                    end
                end
                ST_START, ST_DATA: begin
                    if (tx_bit) begin
                        if (tx_sub_q == `ASPU_TICKS_PER_BIT - 5'h01) begin
                            tx_sub_q <= 5'h00;
                            if (tx_cnt_q == 4'h1) begin
                                o_serial_out_pin <= 1'b1;
                                tx_done_set      <= 1'b1;
                                tx_st_q          <= ST_STOP;
                            end else begin
                                o_serial_out_pin <= tx_shift_q[0];
                                tx_shift_q <= {1'b1, tx_shift_q[8:1]};
                                tx_st_q    <= ST_DATA;
                            end
                            tx_cnt_q <= tx_cnt_q - 4'h1;
                        end else begin
                            tx_sub_q <= tx_sub_q + 5'h01;
                        end
                    end
                end
                ST_STOP: begin
                    if (tx_bit) begin
                        if (tx_sub_q == `ASPU_TICKS_PER_BIT - 5'h01) begin
                            tx_sub_q <= 5'h00;
                            tx_st_q  <= ST_IDLE;
                        end else begin
                            tx_sub_q <= tx_sub_q + 5'h01;
                        end
                    end
                end
                default: tx_st_q <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // Receiver
    // Start edge only counts while idle and enabled
    assign rx_fall = (rx_st_q == ST_IDLE) & rx_prev_q & ~i_serial_in_pin
                     & ctrl_q[`ASPU_BIT_REN];

    // The check bit is the ninth bit in 9-bit frames, else the stop bit
    assign rx_ninth = nine ? rx_shift_q[8] : i_serial_in_pin;
    // Overrun drops the frame because the done flag still stands
    assign rx_ok = ~ctrl_q[`ASPU_BIT_RDONE]
                   & (~ctrl_q[`ASPU_BIT_MCE] | rx_ninth);

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_st_q     <= ST_IDLE;
            rx_shift_q  <= 9'h000;
            rx_cnt_q    <= 4'h0;
            rx_sub_q    <= 5'h00;
            rx_prev_q   <= 1'b1;
            rx_done_set <= 1'b0;
            rx_load     <= 1'b0;
            rx_buf_q    <= 8'h00;
        end else begin
            rx_prev_q   <= i_serial_in_pin;
            rx_done_set <= 1'b0;
            rx_load     <= 1'b0;
            case (rx_st_q)
                ST_IDLE: begin
                    if (rx_fall) begin
                        rx_sub_q <= 5'h00;
                        rx_cnt_q <= frame_bits(nine);
                        rx_st_q  <= ST_START;
                    end
                end
                ST_START: begin
                    // Mid-start sample filters glitches on the line
                    if (rx_os) begin
                        if (rx_sub_q == `ASPU_TICK_MID - 5'h01) begin
                            rx_sub_q <= 5'h00;
                            rx_st_q  <= i_serial_in_pin ? ST_IDLE : ST_DATA;
                        end else begin
                            rx_sub_q <= rx_sub_q + 5'h01;
                        end
                    end
                end
                ST_DATA: begin
                    if (rx_os) begin
                        if (rx_sub_q == `ASPU_TICKS_PER_BIT - 5'h01) begin
                            rx_sub_q <= 5'h00;
                            rx_cnt_q <= rx_cnt_q - 4'h1;
                            if (rx_cnt_q == 4'h1) begin
                                // Stop bit sampled: decide acceptance now
                                rx_st_q <= ST_IDLE;
                                if (rx_ok) begin
                                    rx_done_set <= 1'b1;
                                    rx_load     <= 1'b1;
                                    rx_buf_q    <= nine ? rx_shift_q[7:0]
                                                        : rx_shift_q[8:1];
                                    rx_shift_q[0] <= rx_ninth;
                                end
                            end else begin
                                rx_shift_q <= {i_serial_in_pin, rx_shift_q[8:1]};
                            end
                        end else begin
                            rx_sub_q <= rx_sub_q + 5'h01;
                        end
                    end
                end
                default: rx_st_q <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // Control register
    // Hardware sets win over a software clear in the same cycle
    // Bit 6 is forced high on every write so it always reads one
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= `ASPU_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= i_wdata | `ASPU_CTRL_RESET;
            end
            if (tx_done_set) begin
                ctrl_q[`ASPU_BIT_TDONE] <= 1'b1;
            end
            if (rx_load) begin
                ctrl_q[`ASPU_BIT_RB8] <= rx_shift_q[0];
            end
            if (rx_done_set) begin
                ctrl_q[`ASPU_BIT_RDONE] <= 1'b1;
            end
        end
    end

    // ============================================================
    // Read path and interrupt
    // Transmit data is write-only; reads always see the receive buffer
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (hit(i_addr, `ASPU_CTRL_ADDR)) begin
                o_rdata <= ctrl_q;
            end else if (hit(i_addr, `ASPU_DATA_ADDR)) begin
                o_rdata <= rx_buf_q;
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

    // Level request; it drops when software clears both flags or the interrupt enable goes low
    assign o_irq = i_int_enable &
                   (ctrl_q[`ASPU_BIT_TDONE] | ctrl_q[`ASPU_BIT_RDONE]);
endmodule // aspu_serial_port
`default_nettype wire

/* aspu_regs.vh */
// Register map, field positions, reset values and timing constants of the serial port
`ifndef ASPU_REGS_VH
`define ASPU_REGS_VH
`define ASPU_CTRL_ADDR      8'h98
`define ASPU_DATA_ADDR      8'h99
`define ASPU_CTRL_RESET     8'h40
`define ASPU_BIT_FMT        7
`define ASPU_BIT_UNUSED     6
`define ASPU_BIT_MCE        5
`define ASPU_BIT_REN        4
`define ASPU_BIT_TB8        3
`define ASPU_BIT_RB8        2
`define ASPU_BIT_TDONE      1
`define ASPU_BIT_RDONE      0
`define ASPU_RELOAD_RESET   8'h00
`define ASPU_TICKS_PER_BIT  5'h10
`define ASPU_TICK_MID       5'h08
`define ASPU_BITS_8BIT      4'h9
`define ASPU_BITS_9BIT      4'hA
`endif

/* aspu_bit_timer.v */
// Eight-bit auto-reload bit timer with forced reload and divide-by-two output
`timescale 1ns/1ps
`default_nettype none
module aspu_bit_timer #(
    parameter WIDTH = 8                      // Counter width
) (
    input  wire             i_clock,         // System clock
    input  wire             i_rst_n,         // Asynchronous reset, active low
    input  wire             i_tick,          // Timer count enable pulse
    input  wire [WIDTH-1:0] i_reload,        // Auto-reload value
    input  wire             i_restart,       // Force reload and phase reset
    output wire             o_overflow,      // One-cycle overflow pulse
    output wire             o_half           // Overflow divided by two
);
    reg [WIDTH-1:0] count_q;
    reg             phase_q;
    // ============================================================
    // Counter
    // Overflow fires when the counter wraps from all ones
    assign o_overflow = i_tick & (&count_q) & ~i_restart;
    assign o_half     = o_overflow & phase_q;
    // Restart takes priority so a start edge always realigns the phase
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= {WIDTH{1'b0}};
            phase_q <= 1'b0;
        end else if (i_restart) begin
            count_q <= i_reload;
            phase_q <= 1'b0;
        end else if (i_tick) begin
            if (&count_q) begin
                count_q <= i_reload;
                phase_q <= ~phase_q;
            end else begin
                count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // aspu_bit_timer
`default_nettype wire

/* aspu_serial_port_asserts.sv */
// Port-level assertions for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "aspu_regs.vh"
module aspu_serial_port_asserts (
    input wire logic       i_clock,          // Clock
    input wire logic       i_rst_n,          // Reset
    input wire logic       i_timer_tick,     // Tick
    input wire logic [7:0] i_timer_reload,   // Reload
    input wire logic       i_int_enable,     // Irq enable
    input wire logic [7:0] i_addr,           // Address
    input wire logic       i_wr,             // Write
    input wire logic       i_rd,             // Read
    input wire logic [7:0] i_wdata,          // Write data
    input wire logic [7:0] o_rdata,          // Read data
    input wire logic       i_serial_in_pin,  // Rx line
    input wire logic       o_serial_out_pin, // Tx line
    input wire logic       o_irq             // Irq
);
    // ========
    // Frame tracker; 32 cycles a bit, end margin covers timer phase jitter
    logic       fmt_q;
    logic       ffmt_q;
    logic [8:0] cnt_q;
    logic       start_w;
    logic [8:0] stop_w;
    assign start_w = i_wr && i_addr == `ASPU_DATA_ADDR && cnt_q == 9'h000;
    assign stop_w = ffmt_q ? 9'h150 : 9'h130;
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fmt_q <= 1'b0;
            ffmt_q <= 1'b0;
            cnt_q <= 9'h000;
        end else begin
            if (i_wr && i_addr == `ASPU_CTRL_ADDR)
                fmt_q <= i_wdata[`ASPU_BIT_FMT];
            if (start_w)
                ffmt_q <= fmt_q;
            if (start_w)
                cnt_q <= 9'h001;
            else if (cnt_q == (ffmt_q ? 9'h168 : 9'h148))
                cnt_q <= 9'h000;
            else if (cnt_q != 9'h000)
                cnt_q <= cnt_q + 9'h001;
        end
    end
    // ========
    // Checks
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence ctrl_wr_s;
        i_wr && !i_rd && i_addr == `ASPU_CTRL_ADDR;
    endsequence
    sequence ctrl_rd_s;
        i_rd && !i_wr && i_addr == `ASPU_CTRL_ADDR;
    endsequence
    start_low_a: assert property (start_w |=> !o_serial_out_pin [*8])
        else $error("start bit missing");
    idle_high_a: assert property (cnt_q == 9'h000 |-> o_serial_out_pin)
        else $error("line low while idle");
    stop_high_a: assert property (cnt_q == stop_w |-> o_serial_out_pin)
        else $error("stop bit low");
    tx_irq_a: assert property (cnt_q == stop_w && i_int_enable |-> o_irq)
        else $error("no done flag at stop");
    readback_a: assert property (ctrl_wr_s ##2 ctrl_rd_s |=>
        o_rdata[7:3] == {$past(i_wdata[7], 3), 1'b1, $past(i_wdata[5:3], 3)})
        else $error("control readback wrong");
    rd_hold_a: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved");
    unused_one_a: assert property (ctrl_rd_s |=> o_rdata[6])
        else $error("bit 6 not one");
    unmapped_zero_a: assert property (i_rd && i_addr != `ASPU_CTRL_ADDR &&
        i_addr != `ASPU_DATA_ADDR |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    irq_gate_a: assert property (!i_int_enable |-> !o_irq)
        else $error("irq while disabled");
    flag_sticky_a: assert property (o_irq && !i_wr ##1 i_int_enable |-> o_irq)
        else $error("flag cleared by hardware");
endmodule // aspu_serial_port_asserts
`default_nettype wire

/* aspu_remote_model.sv */
// Remote transceiver model: frame sender and mid-bit sampler
`timescale 1ns/1ps
`default_nettype none
module aspu_remote_model #(
    parameter int BIT = 32          // Cycles a bit
) (
    input  wire logic i_clock,      // Clock
    input  wire logic i_line,       // From port
    output var  logic o_line        // Into port
);
    logic [9:0] got_q[$];           // Captured words
    logic [9:0] w;
    initial o_line = 1'b1;          // Idle high
    // ========
    // One bit for one bit time
    task automatic put(input logic b);
        #2 o_line = b;
        repeat (BIT) @(posedge i_clock);
    endtask
    // Start, data LSB first, optional ninth, stop, then an idle bit
    task automatic send(input logic nine, input logic [7:0] d, input logic n9, input logic s);
        @(posedge i_clock);
        put(1'b0);
        for (int i = 0; i < 8; i++) put(d[i]);
        if (nine) put(n9);
        put(s);
        put(1'b1);
    endtask
    // Ten mid-bit samples after each fall cover both formats
    initial forever begin
        @(negedge i_line);
        repeat (BIT / 2) @(posedge i_clock);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge i_clock);
            w[i] = i_line;
        end
        got_q.push_back(w);
    end
endmodule // aspu_remote_model
`default_nettype wire

/* aspu_serial_port_test.sv */
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "aspu_regs.vh"
module aspu_serial_port_test;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       int_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       rx_w;
    logic       tx_w;
    logic       irq;
    int         error_cnt = 0;
    int         n_compared = 0;
    int         cyc = 0;
    logic [7:0] exp_ctrl = 8'h40;
    logic [7:0] exp_buf = 8'h00;
    logic [7:0] r;
    logic [7:0] d;
    logic       m;
    logic       t;
    logic [9:0] c;
    // Bit 6 set in an entry means leave the control register alone
    logic [9:0] rx_tab [8] = '{10'h110, 10'h140, 10'h030, 10'h010,
                               10'h100, 10'h1B0, 10'h3B0, 10'h090};
    always #12.5 clk = ~clk;
    // Tick every cycle with reload FF: 32 cycles a bit
    aspu_serial_port dut_u (.i_clock(clk), .i_rst_n(rst_n), .i_timer_tick(1'b1),
        .i_timer_reload(8'hFF), .i_int_enable(int_en), .i_addr(addr), .i_wr(wr_en),
        .i_rd(rd_en), .i_wdata(wdata), .o_rdata(rdata), .i_serial_in_pin(rx_w),
        .o_serial_out_pin(tx_w), .o_irq(irq));
    aspu_remote_model #(.BIT(32)) far_u (.i_clock(clk), .i_line(tx_w), .o_line(rx_w));
    // ========
    // Helpers
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        wait_cyc(1);
        addr = a;
        wdata = v;
        wr_en = 1'b1;
        wait_cyc(1);
        wr_en = 1'b0;
        if (a == `ASPU_CTRL_ADDR)
            exp_ctrl = {v[7], 1'b1, v[5:0]};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        wait_cyc(1);
        addr = a;
        rd_en = 1'b1;
        wait_cyc(1);
        rd_en = 1'b0;
        v = rdata;
    endtask
    function automatic logic acc(input logic [7:0] k, input logic n9, input logic s);
        return k[4] && !k[0] && (!k[5] || (k[7] ? n9 : s));
    endfunction
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ========
    // Main sequence
    initial begin
        void'($urandom(28));
        wait_cyc(3);
        rst_n = 1'b1;
        rd(`ASPU_CTRL_ADDR, r);
        check(r, 8'h40);
        rd(8'h97, r);
        check(r, 8'h00);
        wr(`ASPU_CTRL_ADDR, 8'h38);
        rd(`ASPU_CTRL_ADDR, r);
        check(r, 8'h78);
        // Transmit timer needs a full count from zero before its first bit clock
        wait_cyc(256);
        // Transmit in both formats; a write while busy must be dropped
        for (int k = 0; k < 6; k++) begin
            m = k[0];
            t = 1'($urandom_range(1));
            d = 8'($urandom);
            int_en = 1'($urandom_range(1));
            wr(`ASPU_CTRL_ADDR, {m, 3'h0, t, 3'h0});
            wr(`ASPU_DATA_ADDR, d);
            wait_cyc((9 + m) * 32 - 14);
            rd(`ASPU_CTRL_ADDR, r);
            check(r, exp_ctrl);
            wr(`ASPU_DATA_ADDR, ~d);
            wait_cyc(18);
            exp_ctrl[1] = 1'b1;
            rd(`ASPU_CTRL_ADDR, r);
            check(r, exp_ctrl);
            check(irq, int_en);
            wait_cyc(100);
            check(11'(far_u.got_q.size()), 11'h001);
            check({1'b0, far_u.got_q.pop_front()}, {2'h1, m ? t : 1'b1, d});
        end
        rd(`ASPU_DATA_ADDR, r);
        check(r, 8'h00);
        // Receive: checks, overrun, disabled receiver, ninth bit
        for (int k = 0; k < 8; k++) begin
            c = rx_tab[k];
            d = 8'($urandom);
            int_en = 1'($urandom_range(1));
            if (!c[6])
                wr(`ASPU_CTRL_ADDR, c[7:0]);
            wait_cyc($urandom_range(7));
            if (acc(exp_ctrl, c[9], c[8])) begin
                exp_buf = d;
                exp_ctrl[2] = exp_ctrl[7] ? c[9] : c[8];
                exp_ctrl[0] = 1'b1;
            end
            far_u.send(exp_ctrl[7], d, c[9], c[8]);
            rd(`ASPU_CTRL_ADDR, r);
            check(r, exp_ctrl);
            rd(`ASPU_DATA_ADDR, r);
            check(r, exp_buf);
            check(irq, int_en & |exp_ctrl[1:0]);
        end
        finish_test();
    end
endmodule // aspu_serial_port_test
bind aspu_serial_port aspu_serial_port_asserts chk_u (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_timer_tick(i_timer_tick), .i_timer_reload(i_timer_reload),
    .i_int_enable(i_int_enable), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_serial_in_pin(i_serial_in_pin),
    .o_serial_out_pin(o_serial_out_pin), .o_irq(o_irq));
`default_nettype wire
